// [inc/phy_event_defs.vh]
// Register map, field positions and constants of the PHY event block
`ifndef PHY_EVENT_DEFS_VH
`define PHY_EVENT_DEFS_VH

// ----------------------------------------------------------------
// Register addresses on the management port
// ----------------------------------------------------------------
`define ADDR_EVENT_STATUS 5'h12
`define ADDR_FALSE_CARRIER 5'h14
`define ADDR_RX_ERROR 5'h15
`define ADDR_CODING_CONFIG 5'h16

// ----------------------------------------------------------------
// Event status and enables fields
// ----------------------------------------------------------------
`define EVT_PENDING_LSB 8
`define EVT_PENDING_MSB 14
`define EVT_ENABLE_LSB 0
`define EVT_ENABLE_MSB 6
`define EVT_COUNT 7
`define EVT_IDX_ENERGY 6
`define EVT_IDX_LINK 5
`define EVT_IDX_SPEED 4
`define EVT_IDX_DUPLEX 3
`define EVT_IDX_AUTONEG 2
`define EVT_IDX_FC_HALF 1
`define EVT_IDX_RXE_HALF 0
`define EVT_ENABLE_RESET 7'h00

// ----------------------------------------------------------------
// Coding sublayer config fields
// ----------------------------------------------------------------
`define PCS_QUIET_BIT 10
`define PCS_SD_FORCE_BIT 9
`define PCS_RSVD_LSB 11
`define PCS_RSVD_MSB 12
`define PCS_CONFIG_RESET 4'h0

// ----------------------------------------------------------------
// Counters
// ----------------------------------------------------------------
`define CNT_WIDTH 8
`define CNT_MAX 8'hFF
`define CNT_HALF 8'h80
`define CNT_RESET 8'h00

`endif

// [logic/event_latch.v]
// Sticky pending bits, set by events and cleared by a read
`timescale 1ns/1ns
module event_latch #(
    parameter WIDTH = 7
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire [WIDTH-1:0] i_set,
    input wire i_clear,
    output wire [WIDTH-1:0] o_pending
);

reg [WIDTH-1:0] pending_ff;
wire [WIDTH-1:0] nxt_pending;

genvar g;
generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
        // Set wins over the clear of the same cycle
        assign nxt_pending[g] = i_set[g] | (pending_ff[g] & ~i_clear);
    end
endgenerate

always @(posedge i_clock) begin
    if (!i_rst_b) begin
        pending_ff <= {WIDTH{1'b0}};
    end else begin
        pending_ff <= nxt_pending;
    end
end

assign o_pending = pending_ff;

endmodule

// [logic/sat_counter.v]
// Saturating event counter with half-full crossing pulse
`timescale 1ns/1ns
`include "phy_event_defs.vh"
module sat_counter #(
    parameter WIDTH = `CNT_WIDTH
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_inc,
    input wire i_clear,
    output wire [WIDTH-1:0] o_count,
    output wire o_half_event
);

localparam [WIDTH-1:0] MAX = {WIDTH{1'b1}};
localparam [WIDTH-1:0] HALF = {1'b1, {(WIDTH-1){1'b0}}};

reg [WIDTH-1:0] count_ff;
reg [WIDTH-1:0] nxt_count;
wire [WIDTH-1:0] base;

// A clear and an increment together leave a count of one
assign base = i_clear ? {WIDTH{1'b0}} : count_ff;

always @* begin
    nxt_count = base;
    if (i_inc && base != MAX) begin
        nxt_count = base + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

always @(posedge i_clock) begin
    if (!i_rst_b) begin
        count_ff <= {WIDTH{1'b0}};
    end else begin
        count_ff <= nxt_count;
    end
end

// Pulse on the step from below half to half or above
assign o_half_event = (base < HALF) && (nxt_count >= HALF);
assign o_count = count_ff;

endmodule

// [logic/phy_event_status.v]
// PHY event status, error counters and coding sublayer config bits
//
// Behaviour
// - Reserved status and counter bits read zero
// - Energy detect pending bit, clear on read
// - Link change pending bit, clear on read
// - Speed change pending bit, clear on read
// - Duplex change pending bit, clear on read
// - Autoneg complete pending bit, clear on read
// - False carrier half-full pending, clear on read
// - Receive error half-full pending, clear on read
// - Seven enables gate interrupts, reset zero
// - Pending bits set regardless of enables
// - Event interrupt needs event enable and global enable
// - False carrier counter increments per event
// - False carrier counter saturates at FFh
// - Receive error counts invalid symbol in carrier
// - At most one count per carrier event
// - No receive error count during collision
// - Receive error counter saturates, clears on read
// - Config bit 10 selects transmit true quiet
// - Config bit 9 forces signal detect
// - Global enable gates event interrupts
// - Test bit forces interrupt while set
// - Pin select makes shared pin interrupt output
`timescale 1ns/1ns
`include "phy_event_defs.vh"
module phy_event_status #(
    parameter CNT_W = `CNT_WIDTH
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire [4:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [15:0] i_reg_wdata,
    output wire [15:0] o_reg_rdata,
    output wire o_reg_rvalid,
    input wire i_event_irq_global_enable,
    input wire i_forced_test_irq,
    input wire i_irq_pin_select,
    input wire i_energy_event,
    input wire i_link_status,
    input wire i_speed_status,
    input wire i_duplex_status,
    input wire i_autoneg_done,
    input wire i_false_carrier,
    input wire i_carrier_valid,
    input wire i_invalid_symbol,
    input wire i_collision,
    input wire i_pin_in,
    output wire o_pin_out,
    output wire o_pin_oe,
    output wire o_powerdown_request,
    output wire o_irq,
    output wire o_transmit_quiet_select,
    output wire o_forced_signal_detect
);

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
function addr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
        addr_hit = (addr == target);
    end
endfunction

wire rd_status = i_reg_rd & addr_hit(i_reg_addr, `ADDR_EVENT_STATUS);
wire rd_rxerr = i_reg_rd & addr_hit(i_reg_addr, `ADDR_RX_ERROR);
wire wr_status = i_reg_wr & addr_hit(i_reg_addr, `ADDR_EVENT_STATUS);
wire wr_config = i_reg_wr & addr_hit(i_reg_addr, `ADDR_CODING_CONFIG);

// ----------------------------------------------------------------
// Status level tracking
// ----------------------------------------------------------------
reg primed_ff;
reg link_prev_ff;
reg speed_prev_ff;
reg duplex_prev_ff;
reg autoneg_prev_ff;

// Edges are ignored until the previous levels have been sampled once
always @(posedge i_clock) begin
    if (!i_rst_b) begin
        primed_ff <= 1'b0;
        link_prev_ff <= 1'b0;
        speed_prev_ff <= 1'b0;
        duplex_prev_ff <= 1'b0;
        autoneg_prev_ff <= 1'b0;
    end else begin
        primed_ff <= 1'b1;
        link_prev_ff <= i_link_status;
        speed_prev_ff <= i_speed_status;
        duplex_prev_ff <= i_duplex_status;
        autoneg_prev_ff <= i_autoneg_done;
    end
end

wire link_change = primed_ff & (i_link_status ^ link_prev_ff);
wire speed_change = primed_ff & (i_speed_status ^ speed_prev_ff);
wire duplex_change = primed_ff & (i_duplex_status ^ duplex_prev_ff);
wire autoneg_rise = primed_ff & i_autoneg_done & ~autoneg_prev_ff;

// ----------------------------------------------------------------
// Receive error qualification
// ----------------------------------------------------------------
reg carrier_counted_ff;
reg nxt_carrier_counted;
wire rxerr_inc;

assign rxerr_inc = i_carrier_valid & i_invalid_symbol & ~i_collision &
    ~carrier_counted_ff;

always @* begin
    nxt_carrier_counted = carrier_counted_ff;
    if (!i_carrier_valid) begin
        nxt_carrier_counted = 1'b0;
    end else if (rxerr_inc) begin
        nxt_carrier_counted = 1'b1;
    end
end

always @(posedge i_clock) begin
    if (!i_rst_b) begin
        carrier_counted_ff <= 1'b0;
    end else begin
        carrier_counted_ff <= nxt_carrier_counted;
    end
end

// ----------------------------------------------------------------
// Counters
// ----------------------------------------------------------------
wire [CNT_W-1:0] fc_count;
wire [CNT_W-1:0] rxe_count;
wire fc_half;
wire rxe_half;

// False carrier count is read only and never cleared by a read
sat_counter #(
    .WIDTH(CNT_W)
) u_false_carrier (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_inc(i_false_carrier),
    .i_clear(1'b0),
    .o_count(fc_count),
    .o_half_event(fc_half)
);

sat_counter #(
    .WIDTH(CNT_W)
) u_rx_error (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_inc(rxerr_inc),
    .i_clear(rd_rxerr),
    .o_count(rxe_count),
    .o_half_event(rxe_half)
);

// ----------------------------------------------------------------
// Pending event bits
// ----------------------------------------------------------------
wire [`EVT_COUNT-1:0] evt_set;
wire [`EVT_COUNT-1:0] pending;

assign evt_set[`EVT_IDX_ENERGY] = i_energy_event;
assign evt_set[`EVT_IDX_LINK] = link_change;
assign evt_set[`EVT_IDX_SPEED] = speed_change;
assign evt_set[`EVT_IDX_DUPLEX] = duplex_change;
assign evt_set[`EVT_IDX_AUTONEG] = autoneg_rise;
assign evt_set[`EVT_IDX_FC_HALF] = fc_half;
assign evt_set[`EVT_IDX_RXE_HALF] = rxe_half;

// Sets do not look at the enables
event_latch #(
    .WIDTH(`EVT_COUNT)
) u_pending (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_set(evt_set),
    .i_clear(rd_status),
    .o_pending(pending)
);

// ----------------------------------------------------------------
// Writable control bits
// ----------------------------------------------------------------
reg [`EVT_COUNT-1:0] enable_ff;
reg quiet_ff;
reg sd_force_ff;
reg [1:0] pcs_rsvd_ff;

always @(posedge i_clock) begin
    if (!i_rst_b) begin
        enable_ff <= `EVT_ENABLE_RESET;
    end else if (wr_status) begin
        enable_ff <= i_reg_wdata[`EVT_ENABLE_MSB:`EVT_ENABLE_LSB];
    end
end

always @(posedge i_clock) begin
    if (!i_rst_b) begin
        quiet_ff <= 1'b0;
        sd_force_ff <= 1'b0;
        pcs_rsvd_ff <= 2'h0;
    end else if (wr_config) begin
        quiet_ff <= i_reg_wdata[`PCS_QUIET_BIT];
        sd_force_ff <= i_reg_wdata[`PCS_SD_FORCE_BIT];
        // Kept as written; software is expected to write zero here
        pcs_rsvd_ff <= i_reg_wdata[`PCS_RSVD_MSB:`PCS_RSVD_LSB];
    end
end

assign o_transmit_quiet_select = quiet_ff;
assign o_forced_signal_detect = sd_force_ff;

// ----------------------------------------------------------------
// Register words as seen by a read
// ----------------------------------------------------------------
wire energy_event_pending = pending[`EVT_IDX_ENERGY];
wire link_change_pending = pending[`EVT_IDX_LINK];
wire speed_change_pending = pending[`EVT_IDX_SPEED];
wire duplex_change_pending = pending[`EVT_IDX_DUPLEX];
wire autoneg_done_pending = pending[`EVT_IDX_AUTONEG];
wire false_carrier_half_pending = pending[`EVT_IDX_FC_HALF];
wire rx_error_half_pending = pending[`EVT_IDX_RXE_HALF];
wire energy_event_enable = enable_ff[`EVT_IDX_ENERGY];
wire link_change_enable = enable_ff[`EVT_IDX_LINK];
wire speed_change_enable = enable_ff[`EVT_IDX_SPEED];
wire duplex_change_enable = enable_ff[`EVT_IDX_DUPLEX];
wire autoneg_done_enable = enable_ff[`EVT_IDX_AUTONEG];
wire false_carrier_half_enable = enable_ff[`EVT_IDX_FC_HALF];
wire rx_error_half_enable = enable_ff[`EVT_IDX_RXE_HALF];

wire [15:0] status_word;
wire [15:0] fc_word;
wire [15:0] rxe_word;
wire [15:0] config_word;

// Reserved positions are tied to zero, except config bits 12:11, which read back as written
assign status_word = {
    1'b0,
    energy_event_pending,
    link_change_pending,
    speed_change_pending,
    duplex_change_pending,
    autoneg_done_pending,
    false_carrier_half_pending,
    rx_error_half_pending,
    1'b0,
    energy_event_enable,
    link_change_enable,
    speed_change_enable,
    duplex_change_enable,
    autoneg_done_enable,
    false_carrier_half_enable,
    rx_error_half_enable
};
assign fc_word = {{(16-CNT_W){1'b0}}, fc_count};
assign rxe_word = {{(16-CNT_W){1'b0}}, rxe_count};
assign config_word = {3'h0, pcs_rsvd_ff, quiet_ff, sd_force_ff, 9'h000};

// ----------------------------------------------------------------
// Read data
// ----------------------------------------------------------------
reg [15:0] rdata_ff;
reg rvalid_ff;
reg [15:0] nxt_rdata;

always @* begin
    nxt_rdata = 16'h0000;
    case (i_reg_addr)
        `ADDR_EVENT_STATUS: begin
            nxt_rdata = status_word;
        end
        `ADDR_FALSE_CARRIER: begin
            nxt_rdata = fc_word;
        end
        `ADDR_RX_ERROR: begin
            nxt_rdata = rxe_word;
        end
        `ADDR_CODING_CONFIG: begin
            nxt_rdata = config_word;
        end
        default: begin
            nxt_rdata = 16'h0000;
        end
    endcase
end

always @(posedge i_clock) begin
    if (!i_rst_b) begin
        rdata_ff <= 16'h0000;
        rvalid_ff <= 1'b0;
    end else begin
        rvalid_ff <= i_reg_rd;
        if (i_reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end
end

assign o_reg_rdata = rdata_ff;
assign o_reg_rvalid = rvalid_ff;

// ----------------------------------------------------------------
// Interrupt and shared pin
// ----------------------------------------------------------------
reg irq_ff;
reg pin_meta_ff;
reg pin_sync_ff;
wire event_irq;

// Level that follows enabled pending bits until read away
assign event_irq = i_event_irq_global_enable &
    (|(pending & enable_ff));

always @(posedge i_clock) begin
    if (!i_rst_b) begin
        irq_ff <= 1'b0;
        pin_meta_ff <= 1'b1;
        pin_sync_ff <= 1'b1;
    end else begin
        irq_ff <= event_irq | i_forced_test_irq;
        pin_meta_ff <= i_pin_in;
        pin_sync_ff <= pin_meta_ff;
    end
end

assign o_irq = irq_ff;
// Active-low interrupt on the pin only while it is selected as output
assign o_pin_oe = i_irq_pin_select;
assign o_pin_out = ~irq_ff;
assign o_powerdown_request = ~i_irq_pin_select & ~pin_sync_ff;

endmodule

// [tb/phy_event_monitor.sv]
// Port checker of the PHY event status block
`timescale 1ns/1ns
module phy_event_monitor #(
    parameter CNT_W = 8
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire [4:0] i_reg_addr,
    input wire i_reg_wr,
    input wire [15:0] i_reg_wdata,
    input wire [15:0] o_reg_rdata,
    input wire o_reg_rvalid,
    input wire i_event_irq_global_enable,
    input wire i_forced_test_irq,
    input wire i_irq_pin_select,
    input wire o_pin_out,
    input wire o_pin_oe,
    input wire o_powerdown_request,
    input wire o_irq,
    input wire o_transmit_quiet_select,
    input wire o_forced_signal_detect
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    a_status_rsvd_zero: assert property (o_reg_rvalid &&
        $past(i_reg_addr) == 5'h12 |-> !o_reg_rdata[15] && !o_reg_rdata[7])
        else $error("status reserved bit set");
    a_count_upper_zero: assert property (o_reg_rvalid &&
        ($past(i_reg_addr) == 5'h14 || $past(i_reg_addr) == 5'h15)
        |-> o_reg_rdata[15:8] == 8'h00)
        else $error("counter upper byte set");
    a_test_irq_on: assert property (i_forced_test_irq |=> o_irq)
        else $error("test irq not raised");
    a_irq_no_cause: assert property (!i_forced_test_irq &&
        !i_event_irq_global_enable |=> !o_irq)
        else $error("irq without enable");
    a_pin_oe_select: assert property (o_pin_oe == i_irq_pin_select)
        else $error("pin enable wrong");
    a_pin_out_irq: assert property (o_pin_out == !o_irq)
        else $error("pin level wrong");
    a_powerdown_off: assert property (
        o_pin_oe |-> !o_powerdown_request)
        else $error("powerdown while output");
    a_config_write: assert property (i_reg_wr &&
        i_reg_addr == 5'h16 |=> o_transmit_quiet_select ==
        $past(i_reg_wdata[10]) && o_forced_signal_detect ==
        $past(i_reg_wdata[9]))
        else $error("config write lost");
    a_config_hold: assert property (!(i_reg_wr &&
        i_reg_addr == 5'h16) |=> $stable(o_transmit_quiet_select) &&
        $stable(o_forced_signal_detect))
        else $error("config changed alone");
endmodule

bind phy_event_status phy_event_monitor #(.CNT_W(CNT_W)) u_phy_event_monitor (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_event_irq_global_enable(i_event_irq_global_enable),
    .i_forced_test_irq(i_forced_test_irq),
    .i_irq_pin_select(i_irq_pin_select), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_powerdown_request(o_powerdown_request),
    .o_irq(o_irq), .o_transmit_quiet_select(o_transmit_quiet_select),
    .o_forced_signal_detect(o_forced_signal_detect));

// [tb/mgmt_master.sv]
// Management controller model on the register port
`timescale 1ns/1ns
module mgmt_master (
    input wire i_clock,
    input wire [15:0] i_reg_rdata,
    input wire i_reg_rvalid,
    output logic [4:0] o_reg_addr = 5'h00,
    output logic o_reg_wr = 1'b0,
    output logic o_reg_rd = 1'b0,
    output logic [15:0] o_reg_wdata = 16'h0000
);
    // Idle bus shows inverted values so stale data is never mistaken
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        if (a == 5'h16) d[12:11] = 2'h0;
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(posedge i_clock);
        #1;
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
        // Idle edge so a following request never re-raises in this step
        @(posedge i_clock);
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int n;
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(posedge i_clock);
        #1;
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        n = 0;
        while (i_reg_rvalid !== 1'b1 && n < 8) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        d = i_reg_rdata;
        @(posedge i_clock);
        #1;
    endtask
endmodule

// [tb/test_phy_event_status_and_error_counters.sv]
// Self-checking bench of the PHY event status block
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_phy_event_status_and_error_counters;
    logic i_clock = 0, i_rst_b = 0, wr, rd, rvalid;
    logic irq, pout, poe, pdr, tq, sd;
    logic glb = 0, tst = 0, psel = 0, en_ev = 0, link = 0, spd = 0, dup = 0;
    logic anc = 0, fc = 0, cv = 0, isym = 0, col = 0, pin = 1;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, d;
    integer seed = 68298, n_mismatch = 0, check_count = 0, cycles = 0;
    integer cnt, i, j, k;
    always #50 i_clock = ~i_clock;
    phy_event_status u_phy_event_status (.i_clock(i_clock),
        .i_rst_b(i_rst_b), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_event_irq_global_enable(glb), .i_forced_test_irq(tst),
        .i_irq_pin_select(psel), .i_energy_event(en_ev),
        .i_link_status(link), .i_speed_status(spd), .i_duplex_status(dup),
        .i_autoneg_done(anc), .i_false_carrier(fc), .i_carrier_valid(cv),
        .i_invalid_symbol(isym), .i_collision(col), .i_pin_in(pin),
        .o_pin_out(pout), .o_pin_oe(poe), .o_powerdown_request(pdr),
        .o_irq(irq), .o_transmit_quiet_select(tq),
        .o_forced_signal_detect(sd));
    mgmt_master u_mgmt_master (.i_clock(i_clock), .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid), .o_reg_addr(addr), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_wdata(wdata));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sat(input int c);
        return (c > 255) ? 16'h00FF : c[15:0];
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        u_mgmt_master.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic fire(input int n);
        case (n)
            0: en_ev = 1;
            1: link = ~link;
            2: spd = ~spd;
            3: dup = ~dup;
            default: anc = 1;
        endcase
        cyc(1);
        en_ev = 0;
        anc = 0;
        cyc(3);
    endtask
    task automatic print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        cyc(12);
        i_rst_b = 1;
        cyc(2);
        rchk(5'h12, 16'h0000);
        rchk(5'h15, 16'h0000);
        rchk(5'h16, 16'h0000);
        rchk(5'h13, 16'h0000);
        u_mgmt_master.wr(5'h12, 16'hFFFF);
        for (i = 0; i < 5; i++) fire(i);
        `CHK(irq, 1'b0)
        rchk(5'h12, 16'h7C7F);
        rchk(5'h12, 16'h007F);
        glb = 1;
        for (i = 0; i < 5; i++) begin
            fire(i);
            `CHK(irq, 1'b1)
            rchk(5'h12, 16'h007F | (16'h4000 >> i));
            cyc(2);
            `CHK(irq, 1'b0)
        end
        u_mgmt_master.wr(5'h12, 16'h0000);
        fire(1);
        `CHK(irq, 1'b0)
        rchk(5'h12, 16'h2000);
        u_mgmt_master.wr(5'h12, 16'h0003);
        cnt = 0;
        for (i = 0; i < 4; i++) begin
            k = (i == 3) ? 255 : 50 + $unsigned($random(seed)) % 80;
            repeat (k) begin
                fc = 1;
                cyc(1);
                fc = 0;
                cyc(1);
            end
            cnt += k;
            rchk(5'h14, sat(cnt));
        end
        `CHK(irq, 1'b1)
        rchk(5'h12, 16'h0203);
        cnt = 0;
        for (i = 0; i < 600; i++) begin
            k = $unsigned($random(seed)) % 4;
            cv = 1;
            col = (k == 3);
            isym = (k != 0);
            cyc(k + 1);
            isym = 0;
            cv = 0;
            col = 0;
            cyc(2);
            if (k == 1 || k == 2) cnt++;
            if (i == 99) begin
                rchk(5'h15, sat(cnt));
                cnt = 0;
            end
        end
        `CHK(irq, 1'b1)
        rchk(5'h12, 16'h0103);
        rchk(5'h15, sat(cnt));
        rchk(5'h15, 16'h0000);
        u_mgmt_master.wr(5'h16, 16'hFFFF);
        rchk(5'h16, 16'h0600);
        `CHK({tq, sd}, 2'b11)
        u_mgmt_master.wr(5'h16, 16'h0400);
        `CHK({tq, sd}, 2'b10)
        glb = 0;
        u_mgmt_master.wr(5'h12, 16'h007F);
        fire(0);
        `CHK(irq, 1'b0)
        rchk(5'h12, 16'h407F);
        tst = 1;
        cyc(2);
        `CHK(irq, 1'b1)
        psel = 1;
        cyc(2);
        `CHK({poe, pout}, 2'b10)
        tst = 0;
        cyc(2);
        `CHK({irq, pout}, 2'b01)
        pin = 0;
        psel = 0;
        cyc(4);
        `CHK(pdr, 1'b1)
        print_verdict();
    end
endmodule
